/* File: shared/hsir_regs.vh */
// register offsets, reset values and field widths of the status and interrupt block
`ifndef HSIR_REGS_VH
`define HSIR_REGS_VH

// read-only and read-to-clear registers, and the read-write interrupt mask
`define HSIR_OFS_IDENTITY    8'h00
`define HSIR_OFS_STATUS      8'h01
`define HSIR_OFS_INTLATCH    8'h02
`define HSIR_OFS_INTMASK     8'h03
`define HSIR_OFS_RL_RESULT   8'h60
`define HSIR_OFS_OS_RESULT   8'h61
`define HSIR_OFS_VBAT_RESULT 8'h62
`define HSIR_OFS_F0_H        8'h68
`define HSIR_OFS_F0_L        8'h69
`define HSIR_OFS_CONT_H      8'h6a
`define HSIR_OFS_CONT_L      8'h6b

// configuration registers
`define HSIR_OFS_DATA_GAIN   8'h3b
`define HSIR_OFS_PROT_LVL    8'h3e
`define HSIR_OFS_PROT_TIME   8'h3f
`define HSIR_OFS_MEM_ADDR_H  8'h40
`define HSIR_OFS_MEM_ADDR_L  8'h41
`define HSIR_OFS_MEM_DATA    8'h42
`define HSIR_OFS_BRAKE_MAX   8'h44
`define HSIR_OFS_CONTINUOUS_MODE_CTRL   8'h48
`define HSIR_OFS_FPRE_H      8'h49
`define HSIR_OFS_FPRE_L      8'h4a
`define HSIR_OFS_TRACK_H     8'h4b
`define HSIR_OFS_TRACK_L     8'h4c
`define HSIR_OFS_BRAKE_END   8'h4f
`define HSIR_OFS_TRIM        8'h5b
`define HSIR_OFS_DET_CTRL    8'h5f
`define HSIR_OFS_CONV_TEST   8'h66
`define HSIR_OFS_ZC_H        8'h72
`define HSIR_OFS_ZC_L        8'h73
`define HSIR_OFS_DRIVE_DURATION    8'h79
`define HSIR_OFS_NZC_TIME    8'h7a
`define HSIR_OFS_DRIVE_AMPLITUDE     8'h7b
`define HSIR_OFS_OVERDRIVE_AMPLITUDE  8'h7c
`define HSIR_OFS_RESONANCE_COUNT_CFG1    8'h7d
`define HSIR_OFS_RESONANCE_COUNT_CFG2    8'h7e
`define HSIR_OFS_RESONANCE_COUNT_CFG3    8'h7f

// reset values
`define HSIR_RST_STATUS      8'h10
`define HSIR_RST_INTLATCH    8'h10
`define HSIR_RST_INTMASK     8'h7f
`define HSIR_RST_DATA_GAIN   8'h80
`define HSIR_RST_PROT_LVL    8'h3f
`define HSIR_RST_PROT_TIME   8'h00
`define HSIR_RST_ZERO        8'h00
`define HSIR_RST_BRAKE_MAX   8'h12
`define HSIR_RST_CONTINUOUS_MODE_CTRL   8'h98
`define HSIR_RST_FPRE_H      8'h07
`define HSIR_RST_FPRE_L      8'h25
`define HSIR_RST_TRACK_H     8'hb0
`define HSIR_RST_TRACK_L     8'h5d
`define HSIR_RST_BRAKE_END   8'h04
`define HSIR_RST_ZC_H        8'h0f
`define HSIR_RST_ZC_L        8'hf1
`define HSIR_RST_DRIVE_DURATION    8'h3f
`define HSIR_RST_NZC_TIME    8'h1f
`define HSIR_RST_DRIVE_AMPLITUDE     8'h50
`define HSIR_RST_OVERDRIVE_AMPLITUDE  8'h7f
`define HSIR_RST_RESONANCE_COUNT_CFG1    8'h59
`define HSIR_RST_RESONANCE_COUNT_CFG2    8'h05
`define HSIR_RST_RESONANCE_COUNT_CFG3    8'h0f

// soft reset key, interrupt field width, config register count
`define HSIR_SOFT_RST_KEY    8'haa
`define HSIR_IRQ_BITS        7
`define HSIR_CFG_COUNT       26

`endif

/* File: rtl/hsir_bus_edge.v */
// serial bus line edge, start and stop detection
`timescale 1ns/1ps
`default_nettype none
module hsir_bus_edge (
  input  wire clk,
  input  wire rst,
  input  wire scl,
  input  wire sda,
  output wire scl_rise,
  output wire scl_fall,
  output wire bus_start,
  output wire bus_stop
);
  reg scl_q;
  reg sda_q;

  // previous line levels, idle high
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // data moves while the clock line is low, except at start and stop
  assign scl_rise  = scl & ~scl_q;
  assign scl_fall  = ~scl & scl_q;
  assign bus_start = scl & scl_q & sda_q & ~sda;
  assign bus_stop  = scl & scl_q & ~sda_q & sda;
endmodule // hsir_bus_edge
`default_nettype wire

/* File: rtl/hsir_irq_latch.v */
// bank of edge-set, read-to-clear interrupt latches
`timescale 1ns/1ps
`default_nettype none
module hsir_irq_latch #(
  parameter integer      WIDTH   = 7,
  parameter [WIDTH-1:0]  RST_VAL = 7'h10
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] status,
  input  wire             clear,
  output wire [WIDTH-1:0] latched
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg prev;
      reg flag;
      // set on rising status, set beats a clear in the same cycle
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          prev <= RST_VAL[i];
          flag <= RST_VAL[i];
        end else begin
          prev <= status[i];
          flag <= (flag & ~clear) | (status[i] & ~prev);
        end
      end
      assign latched[i] = flag;
    end
  endgenerate
endmodule // hsir_irq_latch
`default_nettype wire

/* File: rtl/hsir_top.v */
// status, interrupt latch and configuration registers behind a serial bus slave
//
// Behaviour
// - The identity register always reads the fixed device code on all eight bits.
// - Writing 0xaa to the identity address puts every configuration register back to default.
// - Status bit 6 is high while wave data overflow or an output-stage DC fault is present.
// - Status bit 5 is high while the supply is below the undervoltage threshold.
// - Status bit 4 is high while the playback buffer is near empty and resets high (0x10).
// - Status bit 3 is high while the playback buffer is near full.
// - Status bit 2 is high while an output-stage overcurrent is present.
// - Status bit 1 is high while an overtemperature is present.
// - Status bit 0 is high to show that a waveform playback has completed.
// - The interrupt register latches each status bit in place, clears on read, resets to 0x10.
// - A read-write mask register holds one mask per latch, all seven set after reset.
`timescale 1ns/1ps
`default_nettype none
`include "hsir_regs.vh"
module hsir_top #(
  parameter [6:0]   DEV_ADDR    = 7'h40,
  parameter [7:0]   DEVICE_CODE = 8'h5c,  // arbitrary value
  parameter integer NCFG        = `HSIR_CFG_COUNT
) (
  input  wire              clk,
  input  wire              rst,
  input  wire              scl,
  input  wire              sda_in,
  output wire              sda_out,
  output wire              sda_oe,
  input  wire              overflow_cond,
  input  wire              undervoltage_flag,
  input  wire              buffer_near_empty_flag,
  input  wire              buffer_near_full_flag,
  input  wire              overcurrent_flag,
  input  wire              overtemp_flag,
  input  wire              playback_done_flag,
  input  wire [7:0]        load_resistance_in,
  input  wire [7:0]        offset_in,
  input  wire [7:0]        battery_voltage_in,
  input  wire [7:0]        resonance_high_in,
  input  wire [7:0]        resonance_low_in,
  input  wire [7:0]        cont_freq_high_in,
  input  wire [7:0]        cont_freq_low_in,
  output wire [8*NCFG-1:0] cfg_flat,
  output wire              irq
);
  localparam [2:0] S_IDLE   = 3'd0;
  localparam [2:0] S_ADDR   = 3'd1;
  localparam [2:0] S_ACK_A  = 3'd2;
  localparam [2:0] S_WR     = 3'd3;
  localparam [2:0] S_ACK_W  = 3'd4;
  localparam [2:0] S_RD     = 3'd5;
  localparam [2:0] S_RD_ACK = 3'd6;
  localparam [7:0] LATCH_RST = `HSIR_RST_INTLATCH; // full byte, sliced to the latch width below

  // offset of configuration register slot i
  function [7:0] cfg_addr;
    input integer i;
    begin
      case (i)
        0:       cfg_addr = `HSIR_OFS_INTMASK;
        1:       cfg_addr = `HSIR_OFS_DATA_GAIN;
        2:       cfg_addr = `HSIR_OFS_PROT_LVL;
        3:       cfg_addr = `HSIR_OFS_PROT_TIME;
        4:       cfg_addr = `HSIR_OFS_MEM_ADDR_H;
        5:       cfg_addr = `HSIR_OFS_MEM_ADDR_L;
        6:       cfg_addr = `HSIR_OFS_MEM_DATA;
        7:       cfg_addr = `HSIR_OFS_BRAKE_MAX;
        8:       cfg_addr = `HSIR_OFS_CONTINUOUS_MODE_CTRL;
        9:       cfg_addr = `HSIR_OFS_FPRE_H;
        10:      cfg_addr = `HSIR_OFS_FPRE_L;
        11:      cfg_addr = `HSIR_OFS_TRACK_H;
        12:      cfg_addr = `HSIR_OFS_TRACK_L;
        13:      cfg_addr = `HSIR_OFS_BRAKE_END;
        14:      cfg_addr = `HSIR_OFS_TRIM;
        15:      cfg_addr = `HSIR_OFS_DET_CTRL;
        16:      cfg_addr = `HSIR_OFS_CONV_TEST;
        17:      cfg_addr = `HSIR_OFS_ZC_H;
        18:      cfg_addr = `HSIR_OFS_ZC_L;
        19:      cfg_addr = `HSIR_OFS_DRIVE_DURATION;
        20:      cfg_addr = `HSIR_OFS_NZC_TIME;
        21:      cfg_addr = `HSIR_OFS_DRIVE_AMPLITUDE;
        22:      cfg_addr = `HSIR_OFS_OVERDRIVE_AMPLITUDE;
        23:      cfg_addr = `HSIR_OFS_RESONANCE_COUNT_CFG1;
        24:      cfg_addr = `HSIR_OFS_RESONANCE_COUNT_CFG2;
        default: cfg_addr = `HSIR_OFS_RESONANCE_COUNT_CFG3;
      endcase
    end
  endfunction

  // default value of configuration register slot i
  function [7:0] cfg_rst;
    input integer i;
    begin
      case (i)
        0:       cfg_rst = `HSIR_RST_INTMASK;
        1:       cfg_rst = `HSIR_RST_DATA_GAIN;
        2:       cfg_rst = `HSIR_RST_PROT_LVL;
        3:       cfg_rst = `HSIR_RST_PROT_TIME;
        7:       cfg_rst = `HSIR_RST_BRAKE_MAX;
        8:       cfg_rst = `HSIR_RST_CONTINUOUS_MODE_CTRL;
        9:       cfg_rst = `HSIR_RST_FPRE_H;
        10:      cfg_rst = `HSIR_RST_FPRE_L;
        11:      cfg_rst = `HSIR_RST_TRACK_H;
        12:      cfg_rst = `HSIR_RST_TRACK_L;
        13:      cfg_rst = `HSIR_RST_BRAKE_END;
        17:      cfg_rst = `HSIR_RST_ZC_H;
        18:      cfg_rst = `HSIR_RST_ZC_L;
        19:      cfg_rst = `HSIR_RST_DRIVE_DURATION;
        20:      cfg_rst = `HSIR_RST_NZC_TIME;
        21:      cfg_rst = `HSIR_RST_DRIVE_AMPLITUDE;
        22:      cfg_rst = `HSIR_RST_OVERDRIVE_AMPLITUDE;
        23:      cfg_rst = `HSIR_RST_RESONANCE_COUNT_CFG1;
        24:      cfg_rst = `HSIR_RST_RESONANCE_COUNT_CFG2;
        25:      cfg_rst = `HSIR_RST_RESONANCE_COUNT_CFG3;
        default: cfg_rst = `HSIR_RST_ZERO;
      endcase
    end
  endfunction

  wire       scl_rise;
  wire       scl_fall;
  wire       bus_start;
  wire       bus_stop;
  reg  [2:0] state;
  reg  [3:0] bit_cnt;
  reg  [7:0] rx_shift;
  reg  [7:0] tx_shift;
  reg        rw_bit;
  reg        first_byte;
  reg        master_nack;
  reg  [7:0] ptr;
  reg        wr_stb;
  reg  [7:0] wr_addr;
  reg  [7:0] wr_data;
  reg  [7:0] status;
  reg  [7:0] rd_data;
  wire       tx_load;
  wire       soft_rst;
  wire       latch_clear;
  wire [`HSIR_IRQ_BITS-1:0] latched;
  wire [7:0] intmask;

  hsir_bus_edge u_edge (
    .clk       (clk),
    .rst       (rst),
    .scl       (scl),
    .sda       (sda_in),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .bus_start (bus_start),
    .bus_stop  (bus_stop)
  );

  // a byte goes out after the address ack, or after the host acks the last one
  assign tx_load = scl_fall & (((state == S_ACK_A) & rw_bit) |
                               ((state == S_RD_ACK) & ~master_nack));

  // serial slave: address, pointer byte, then auto-incrementing data
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= S_IDLE;
      bit_cnt     <= 4'h0;
      rx_shift    <= 8'h00;
      tx_shift    <= 8'h00;
      rw_bit      <= 1'b0;
      first_byte  <= 1'b0;
      master_nack <= 1'b0;
      ptr         <= 8'h00;
      wr_stb      <= 1'b0;
      wr_addr     <= 8'h00;
      wr_data     <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (bus_start) begin
        state   <= S_ADDR;
        bit_cnt <= 4'h0;
      end else if (bus_stop) begin
        state <= S_IDLE;
      end else begin
        if (scl_rise) begin
          rx_shift <= {rx_shift[6:0], sda_in};
          bit_cnt  <= bit_cnt + 4'h1;
          if (state == S_RD_ACK) begin
            master_nack <= sda_in;
          end
        end
        if (tx_load) begin
          tx_shift <= rd_data;
          ptr      <= ptr + 8'h01;
          state    <= S_RD;
          bit_cnt  <= 4'h0;
        end else if (scl_fall) begin
          case (state)
            S_ADDR: begin
              if (bit_cnt == 4'h8) begin
                if (rx_shift[7:1] == DEV_ADDR) begin
                  state  <= S_ACK_A;
                  rw_bit <= rx_shift[0];
                end else begin
                  state <= S_IDLE;
                end
              end
            end
            S_ACK_A: begin
              state      <= S_WR;
              bit_cnt    <= 4'h0;
              first_byte <= 1'b1;
            end
            S_WR: begin
              if (bit_cnt == 4'h8) begin
                state <= S_ACK_W;
                if (first_byte) begin
                  ptr        <= rx_shift;
                  first_byte <= 1'b0;
                end else begin
                  wr_stb  <= 1'b1;
                  wr_addr <= ptr;
                  wr_data <= rx_shift;
                  ptr     <= ptr + 8'h01;
                end
              end
            end
            S_ACK_W: begin
              state   <= S_WR;
              bit_cnt <= 4'h0;
            end
            S_RD: begin
              if (bit_cnt == 4'h8) begin
                state <= S_RD_ACK;
              end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
              end
            end
            S_RD_ACK: begin
              state <= S_IDLE;  // host said nack
            end
            default: begin
              state <= S_IDLE;
            end
          endcase
        end
      end
    end
  end

  // open-drain data line: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = (state == S_ACK_A) | (state == S_ACK_W) | ((state == S_RD) & ~tx_shift[7]);

  // live status, registered so it resets to the documented value
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= `HSIR_RST_STATUS;
    end else begin
      status[7] <= 1'b0;
      status[6] <= overflow_cond;
      status[5] <= undervoltage_flag;
      status[4] <= buffer_near_empty_flag;
      status[3] <= buffer_near_full_flag;
      status[2] <= overcurrent_flag;
      status[1] <= overtemp_flag;
      status[0] <= playback_done_flag;
    end
  end

  // key write to the identity address restores configuration defaults
  assign soft_rst = wr_stb & (wr_addr == `HSIR_OFS_IDENTITY) &
                    (wr_data == `HSIR_SOFT_RST_KEY);

  // configuration register slots
  genvar gi;
  generate
    for (gi = 0; gi < NCFG; gi = gi + 1) begin : g_cfg
      localparam [7:0] ADDR_I = cfg_addr(gi);
      localparam [7:0] RST_I  = cfg_rst(gi);
      reg [7:0] value;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          value <= RST_I;
        end else if (soft_rst) begin
          value <= RST_I;
        end else if (wr_stb && (wr_addr == ADDR_I)) begin
          value <= wr_data;
        end
      end
      assign cfg_flat[8*gi+7:8*gi] = value;
    end
  endgenerate

  // mask sits in slot 0, all seven masks set at reset
  assign intmask = cfg_flat[7:0];

  // reading the latch register clears what was read
  assign latch_clear = tx_load & (ptr == `HSIR_OFS_INTLATCH);

  hsir_irq_latch #(
    .WIDTH   (`HSIR_IRQ_BITS),
    .RST_VAL (LATCH_RST[`HSIR_IRQ_BITS-1:0])
  ) u_latch (
    .clk     (clk),
    .rst     (rst),
    .status  (status[`HSIR_IRQ_BITS-1:0]),
    .clear   (latch_clear),
    .latched (latched)
  );

  // unmasked latched events drive the interrupt line
  assign irq = |(latched & ~intmask[`HSIR_IRQ_BITS-1:0]);

  // read data selection at the pointer
  integer k;
  always @* begin
    rd_data = 8'h00;
    case (ptr)
      `HSIR_OFS_IDENTITY:    rd_data = DEVICE_CODE;
      `HSIR_OFS_STATUS:      rd_data = status;
      `HSIR_OFS_INTLATCH:    rd_data = {1'b0, latched};
      `HSIR_OFS_RL_RESULT:   rd_data = load_resistance_in;
      `HSIR_OFS_OS_RESULT:   rd_data = offset_in;
      `HSIR_OFS_VBAT_RESULT: rd_data = battery_voltage_in;
      `HSIR_OFS_F0_H:        rd_data = resonance_high_in;
      `HSIR_OFS_F0_L:        rd_data = resonance_low_in;
      `HSIR_OFS_CONT_H:      rd_data = cont_freq_high_in;
      `HSIR_OFS_CONT_L:      rd_data = cont_freq_low_in;
      default: begin
        for (k = 0; k < NCFG; k = k + 1) begin
          if (ptr == cfg_addr(k)) begin
            rd_data = cfg_flat[8*k +: 8];
          end
        end
      end
    endcase
  end
endmodule // hsir_top
`default_nettype wire

/* File: test/hsir_props.sv */
// assertion checker for the status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module hsir_props #(
  parameter integer NCFG = 26
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              scl,
  input wire logic              sda_out,
  input wire logic              sda_oe,
  input wire logic              overflow_cond,
  input wire logic              undervoltage_flag,
  input wire logic              buffer_near_empty_flag,
  input wire logic              buffer_near_full_flag,
  input wire logic              overcurrent_flag,
  input wire logic              overtemp_flag,
  input wire logic              playback_done_flag,
  input wire logic [8*NCFG-1:0] cfg_flat,
  input wire logic              irq
);
  logic [6:0] conds;
  logic [6:0] mask;
  // conditions and masks in register bit order
  assign conds = {overflow_cond, undervoltage_flag, buffer_near_empty_flag,
                  buffer_near_full_flag, overcurrent_flag, overtemp_flag, playback_done_flag};
  assign mask = cfg_flat[6:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_cfg_reset;
    $fell(rst) |-> mask == 7'h7f && cfg_flat[15:8] == 8'h80;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config not at defaults");
  property p_irq_reset;
    $fell(rst) |-> !irq && !sda_oe;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("irq or data drive after reset");
  property p_edge_irq;
    (conds & ~$past(conds) & ~mask) != 7'h00 |-> ##2 irq;
  endproperty
  a_edge_irq: assert property (p_edge_irq) else $error("unmasked edge gave no irq");
  property p_irq_cause;
    $rose(irq) |-> mask != $past(mask) || ($past(conds, 2) & ~$past(conds, 3) & ~mask) != 7'h00;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
  property p_irq_holds;
    irq && scl && $past(scl) && $past(scl, 2) |=> irq || mask != $past(mask);
  endproperty
  a_irq_holds: assert property (p_irq_holds) else $error("irq dropped without a read");
  property p_masked_quiet;
    mask == 7'h7f |-> !irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("irq while all masked");
  property p_oe_scl_low;
    $changed(sda_oe) |-> !scl;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data drive changed with clock high");
  property p_sda_out_zero;
    sda_oe |-> sda_out == 1'b0;
  endproperty
  a_sda_out_zero: assert property (p_sda_out_zero) else $error("data line driven high");
  c_irq_rise: cover property ($rose(irq));
  c_ack: cover property ($rose(sda_oe));
  c_mask_write: cover property (mask != $past(mask));
endmodule // hsir_props
bind hsir_top hsir_props #(.NCFG(NCFG)) u_props (
  .clk(clk), .rst(rst), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe),
  .overflow_cond(overflow_cond), .undervoltage_flag(undervoltage_flag),
  .buffer_near_empty_flag(buffer_near_empty_flag), .buffer_near_full_flag(buffer_near_full_flag),
  .overcurrent_flag(overcurrent_flag), .overtemp_flag(overtemp_flag),
  .playback_done_flag(playback_done_flag), .cfg_flat(cfg_flat), .irq(irq));
`default_nettype wire

/* File: test/hsir_host.sv */
// bus host model driving the serial clock and pulling the data line
`timescale 1ns/1ps
`default_nettype none
module hsir_host #(
  parameter integer Q = 3
) (
  input  wire logic clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_low
);
  // bus idle at time zero
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // wait a number of clock edges
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one bit: data set with clock low, line sampled in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    hold(Q);
    scl <= 1'b1;
    hold(Q);
    r = sda_line;
    hold(Q);
    scl <= 1'b0;
    hold(Q);
  endtask
  // start or repeated start, leaves the clock low
  task automatic start();
    sda_low <= 1'b0;
    hold(Q);
    scl <= 1'b1;
    hold(Q);
    sda_low <= 1'b1;
    hold(Q);
    scl <= 1'b0;
    hold(Q);
  endtask
  // stop, leaves the bus idle
  task automatic stop();
    sda_low <= 1'b1;
    hold(Q);
    scl <= 1'b1;
    hold(Q);
    sda_low <= 1'b0;
    hold(Q);
  endtask
  // one byte msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] r,
                      output logic ack_line);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ack_bit, ack_line);
  endtask
endmodule // hsir_host
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [6:0] ADDR = 7'h40;
  localparam logic [7:0] CODE = 8'h3c; // arbitrary value
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [6:0]  cond = 7'h10;
  logic [7:0]  res_v [7] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77};
  logic        scl, sda_low, sda_oe, sda_out, irq;
  wire         sda_line;
  logic [207:0] cfg_flat;
  int          n_errors = 0;
  int          cmp_count = 0;
  // pulled-up data line
  assign sda_line = !(sda_oe || sda_low);
  hsir_host u_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  hsir_top #(.DEV_ADDR(ADDR), .DEVICE_CODE(CODE)) u_hsir_top (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .overflow_cond(cond[6]), .undervoltage_flag(cond[5]), .buffer_near_empty_flag(cond[4]),
    .buffer_near_full_flag(cond[3]), .overcurrent_flag(cond[2]), .overtemp_flag(cond[1]),
    .playback_done_flag(cond[0]), .load_resistance_in(res_v[0]), .offset_in(res_v[1]),
    .battery_voltage_in(res_v[2]), .resonance_high_in(res_v[3]), .resonance_low_in(res_v[4]),
    .cont_freq_high_in(res_v[5]), .cont_freq_low_in(res_v[6]), .cfg_flat(cfg_flat), .irq(irq));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // register write: address, pointer, data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic k;
    u_host.start();
    u_host.xfer({ADDR, 1'b0}, 1'b1, r, k);
    u_host.xfer(a, 1'b1, r, k);
    u_host.xfer(d, 1'b1, r, k);
    chk("write ack", {7'h00, k}, 8'h00);
    u_host.stop();
  endtask
  // register read: pointer, repeated start, one byte closed by no acknowledge
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic k;
    u_host.start();
    u_host.xfer({ADDR, 1'b0}, 1'b1, r, k);
    u_host.xfer(a, 1'b1, r, k);
    u_host.start();
    u_host.xfer({ADDR, 1'b1}, 1'b1, r, k);
    u_host.xfer(8'hff, 1'b1, r, k);
    u_host.stop();
    chk(what, r, exp);
  endtask
  // defaults, identity, results and unmapped space after reset
  task automatic t_reset_values();
    logic [7:0] ofs [8] = '{8'h03, 8'h3b, 8'h3e, 8'h44, 8'h48, 8'h4b, 8'h73, 8'h7f};
    logic [7:0] dflt [8] = '{8'h7f, 8'h80, 8'h3f, 8'h12, 8'h98, 8'hb0, 8'hf1, 8'h0f};
    logic [7:0] res_ofs [7] = '{8'h60, 8'h61, 8'h62, 8'h68, 8'h69, 8'h6a, 8'h6b};
    chk("irq after reset", {7'h00, irq}, 8'h00);
    rd_chk("identity", 8'h00, CODE);
    rd_chk("status", 8'h01, 8'h10);
    rd_chk("latch", 8'h02, 8'h10);
    rd_chk("latch cleared", 8'h02, 8'h00);
    for (int i = 0; i < 8; i++) rd_chk("default", ofs[i], dflt[i]);
    for (int i = 0; i < 7; i++) rd_chk("result", res_ofs[i], res_v[i]);
    res_v <= '{8'h9e, 8'h8d, 8'h7c, 8'h6b, 8'h5a, 8'h49, 8'h38};
    u_host.hold(1);
    for (int i = 0; i < 7; i++) rd_chk("result moved", res_ofs[i], res_v[i]);
    rd_chk("unmapped", 8'h05, 8'h00);
  endtask
  // two-byte write and two-byte read with auto-increment, foreign address refused
  task automatic t_burst();
    logic [7:0] r;
    logic k;
    u_host.start();
    u_host.xfer({ADDR, 1'b0}, 1'b1, r, k);
    u_host.xfer(8'h72, 1'b1, r, k);
    u_host.xfer(8'h5a, 1'b1, r, k);
    u_host.xfer(8'h3c, 1'b1, r, k);
    u_host.start();
    u_host.xfer({ADDR, 1'b0}, 1'b1, r, k);
    u_host.xfer(8'h72, 1'b1, r, k);
    u_host.start();
    u_host.xfer({ADDR, 1'b1}, 1'b1, r, k);
    u_host.xfer(8'hff, 1'b0, r, k);
    chk("burst first", r, 8'h5a);
    u_host.xfer(8'hff, 1'b1, r, k);
    u_host.stop();
    chk("burst second", r, 8'h3c);
    u_host.start();
    u_host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, r, k);
    u_host.stop();
    chk("foreign address ack", {7'h00, k}, 8'h01);
  endtask
  // each condition alone: status follows, latch holds after it goes away
  task automatic t_status_bits();
    for (int i = 0; i < 7; i++) begin
      cond <= 7'h01 << i;
      u_host.hold(4);
      rd_chk("status bit", 8'h01, 8'h01 << i);
      cond <= 7'h00;
      u_host.hold(4);
      rd_chk("latched bit", 8'h02, 8'h01 << i);
      rd_chk("latch after read", 8'h02, 8'h00);
    end
  endtask
  // masked latch keeps irq low; unmask, read clear, fresh edge
  task automatic t_irq_mask();
    cond <= 7'h04;
    u_host.hold(4);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(8'h03, 8'h7b);
    chk("irq unmasked", {7'h00, irq}, 8'h01);
    rd_chk("latch", 8'h02, 8'h04);
    chk("irq after clear", {7'h00, irq}, 8'h00);
    cond <= 7'h00;
    u_host.hold(2);
    cond <= 7'h04;
    u_host.hold(3);
    chk("irq new edge", {7'h00, irq}, 8'h01);
    rd_chk("latch again", 8'h02, 8'h04);
    cond <= 7'h00;
  endtask
  // wrong key ignored, key restores defaults, read-only write ignored
  task automatic t_soft_reset();
    wr(8'h3b, 8'h12);
    wr(8'h00, 8'h55);
    wr(8'h01, 8'hff);
    rd_chk("status kept", 8'h01, 8'h00);
    rd_chk("gain kept", 8'h3b, 8'h12);
    chk("mask kept", cfg_flat[7:0], 8'h7b);
    wr(8'h00, 8'haa);
    rd_chk("gain default", 8'h3b, 8'h80);
    rd_chk("mask default", 8'h03, 8'h7f);
    rd_chk("zc default", 8'h72, 8'h0f);
    rd_chk("identity", 8'h00, CODE);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // clock
  always #2 clk = ~clk;
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    u_host.hold(2);
    t_reset_values();
    t_status_bits();
    t_irq_mask();
    t_burst();
    t_soft_reset();
    end_sim();
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule // testbench
`default_nettype wire
